// ---- rtl/ctpwm_pkg.sv ----
// package for the compact timer with pwm: register map, field layout, types
package ctpwm_pkg;
	localparam int CTPWM_CNT_W = 10;
	localparam int CTPWM_ADDR_W = 3;
	// register indices (word addresses on the bus)
	localparam logic [2:0] CTPWM_REG_CTRL0 = 3'h0;
	localparam logic [2:0] CTPWM_REG_CTRL1 = 3'h1;
	localparam logic [2:0] CTPWM_REG_CNT_LO = 3'h2;
	localparam logic [2:0] CTPWM_REG_CNT_HI = 3'h3;
	localparam logic [2:0] CTPWM_REG_CMP_LO = 3'h4;
	localparam logic [2:0] CTPWM_REG_CMP_HI = 3'h5;
	localparam logic [2:0] CTPWM_REG_STATUS = 3'h6;
	// reset values
	localparam logic [7:0] CTPWM_CTRL0_RST = 8'h00;
	localparam logic [7:0] CTPWM_CTRL1_RST = 8'h00;
	localparam logic [9:0] CTPWM_CMP_RST = 10'h000;
	// control 0 field positions
	localparam int CTPWM_C0_PAUSE = 7;
	localparam int CTPWM_C0_CKSEL_LSB = 4;
	localparam int CTPWM_C0_RUN = 3;
	localparam int CTPWM_C0_PER_LSB = 0;
	// control 1 field positions
	localparam int CTPWM_C1_MODE_LSB = 6;
	localparam int CTPWM_C1_OFN_LSB = 4;
	localparam int CTPWM_C1_OCTL = 3;
	localparam int CTPWM_C1_POL = 2;
	localparam int CTPWM_C1_PDSEL = 1;
	localparam int CTPWM_C1_CLRSEL = 0;
	// prescaler ratios
	localparam int CTPWM_DIV_SYS4 = 4;
	localparam int CTPWM_DIV_H16 = 16;
	localparam int CTPWM_DIV_H64 = 64;

	typedef enum logic [1:0] {
		CTPWM_MODE_CMP = 2'b00,
		CTPWM_MODE_UNDEF = 2'b01,
		CTPWM_MODE_PWM = 2'b10,
		CTPWM_MODE_TMR = 2'b11
	} ctpwm_mode_t;

	typedef enum logic [2:0] {
		CTPWM_CK_SYS4 = 3'b000,
		CTPWM_CK_SYS = 3'b001,
		CTPWM_CK_H16 = 3'b010,
		CTPWM_CK_H64 = 3'b011,
		CTPWM_CK_SUB0 = 3'b100,
		CTPWM_CK_SUB1 = 3'b101,
		CTPWM_CK_PINR = 3'b110,
		CTPWM_CK_PINF = 3'b111
	} ctpwm_cksel_t;

	typedef struct packed {
		logic pause;
		ctpwm_cksel_t cksel;
		logic run;
		logic [2:0] period;
	} ctpwm_ctrl0_t;

	typedef struct packed {
		ctpwm_mode_t mode;
		logic [1:0] ofn;
		logic octl;
		logic pol;
		logic pdsel;
		logic clrsel;
	} ctpwm_ctrl1_t;

	// avalon-mm slave request bundle
	typedef struct packed {
		logic [CTPWM_ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} ctpwm_av_req_t;

	// avalon-mm slave answer bundle
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} ctpwm_av_rsp_t;
endpackage

// ---- rtl/ctpwm_top.sv ----
// compact 10-bit timer with compare-match and pwm output, avalon-mm slave
// Contract
// - ten-bit up counter advances on every active edge of the count clock
// - period comparator checks all ten counter bits against period times 128 minus one
// - match-a comparator checks all ten counter bits
// - run rising clears counter; run falling stops and keeps value
// - run rising returns pin to initial level in compare mode
// - pause holds counter; counting resumes from held value on release
// - clock select picks sys/4, sys, high/16, high/64, sub, pin rise or fall
// - period value n gives match after n*128 counts; zero means 1024
// - period zero lets counter run to maximum and clear by overflow
// - mode field: compare, undefined, pwm, timer; pin undefined in timer mode
// - compare mode match-a: none, low, high, toggle per output function
// - pwm mode output function: inactive, active, waveform, undefined
// - match leaves pin unchanged when requested level equals initial level
// - output control sets initial level or pwm active polarity; none in timer
// - polarity bit inverts pin; no effect in timer mode
// - period/duty select swaps roles of period field and compare value
// - clear select: match-a clears, else period match or overflow at zero
// - pwm mode ignores clear select; period/duty select picks clearing match
// - counter readable only via low byte and high byte, upper bits zero
// - counter clears on overflow or selected match, raising event flags except on overflow with clear select set outside pwm mode
// - compare low write buffered; high write commits; high read latches low
// - with clear select set outside pwm mode, period match flag is never raised
// - pwm duty at or above period gives continuously active output
`timescale 1ns/1ps
module ctpwm_top
	import ctpwm_pkg::*;
#(
	parameter int CNT_W = CTPWM_CNT_W
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire ctpwm_pkg::ctpwm_av_req_t av_req,
	output ctpwm_pkg::ctpwm_av_rsp_t av_rsp,
	input wire logic high_clk_en,
	input wire logic sub_clk_en,
	input wire logic external_count_pin,
	output logic timer_output_pin,
	output logic match_a_event,
	output logic period_match_event
);
	import ctpwm_pkg::*;

	ctpwm_ctrl0_t ctrl0_q;
	ctpwm_ctrl1_t ctrl1_q;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] cmp_q;
	logic [7:0] buf_q;
	logic run_q;
	logic pin_q;
	logic ext_q;
	logic [1:0] div4_q;
	logic [3:0] div16_q;
	logic [5:0] div64_q;
	logic match_a_flag_q;
	logic period_match_flag_q;
	logic [31:0] rdata_q;
	logic rvalid_q;

	logic wr_ctrl0;
	logic wr_ctrl1;
	logic wr_cmp_lo;
	logic wr_cmp_hi;
	logic rd_cnt_hi;
	logic rd_cmp_hi;
	logic wr_status;
	logic tick;
	logic run_rise;
	logic counting;
	logic match_a;
	logic match_p;
	logic overflow;
	logic clear_cnt;
	logic pwm_mode;
	logic [10:0] pwm_period;
	logic [10:0] pwm_duty;
	logic pwm_wave;
	logic pin_level;

	function automatic logic [10:0] period_counts(input logic [2:0] p);
		// zero stands for the full counter span
		period_counts = (p == 3'h0) ? 11'h400 : {1'b0, p, 7'h00};
	endfunction

	// bus decode: writes complete at once, reads take one wait cycle
	assign wr_ctrl0 = av_req.write && av_req.byteenable[0] && av_req.address == CTPWM_REG_CTRL0;
	assign wr_ctrl1 = av_req.write && av_req.byteenable[0] && av_req.address == CTPWM_REG_CTRL1;
	assign wr_cmp_lo = av_req.write && av_req.byteenable[0] && av_req.address == CTPWM_REG_CMP_LO;
	assign wr_cmp_hi = av_req.write && av_req.byteenable[0] && av_req.address == CTPWM_REG_CMP_HI;
	assign wr_status = av_req.write && av_req.byteenable[0] && av_req.address == CTPWM_REG_STATUS;
	assign rd_cnt_hi = av_req.read && !rvalid_q && av_req.address == CTPWM_REG_CNT_HI;
	assign rd_cmp_hi = av_req.read && !rvalid_q && av_req.address == CTPWM_REG_CMP_HI;
	assign av_rsp.waitrequest = av_req.read && !rvalid_q;
	assign av_rsp.readdata = rdata_q;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl0_q <= CTPWM_CTRL0_RST;
			ctrl1_q <= CTPWM_CTRL1_RST;
		end else begin
			if (wr_ctrl0) begin
				ctrl0_q <= av_req.writedata[7:0];
			end
			if (wr_ctrl1) begin
				ctrl1_q <= av_req.writedata[7:0];
			end
		end
	end

	// compare register pair behind the shared byte buffer
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			buf_q <= 8'h00;
			cmp_q <= CTPWM_CMP_RST;
		end else if (wr_cmp_lo) begin
			buf_q <= av_req.writedata[7:0];
		end else if (wr_cmp_hi) begin
			cmp_q <= {av_req.writedata[1:0], buf_q};
		end else if (rd_cnt_hi) begin
			buf_q <= count_q[7:0];
		end else if (rd_cmp_hi) begin
			buf_q <= cmp_q[7:0];
		end
	end

	// low bytes read the buffer, so read the high byte first for a coherent pair
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= av_req.read && !rvalid_q;
			if (av_req.read && !rvalid_q) begin
				unique case (av_req.address)
					CTPWM_REG_CTRL0: rdata_q <= {24'h000000, ctrl0_q};
					CTPWM_REG_CTRL1: rdata_q <= {24'h000000, ctrl1_q};
					CTPWM_REG_CNT_LO: rdata_q <= {24'h000000, buf_q};
					CTPWM_REG_CNT_HI: rdata_q <= {30'h00000000, count_q[9:8]};
					CTPWM_REG_CMP_LO: rdata_q <= {24'h000000, buf_q};
					CTPWM_REG_CMP_HI: rdata_q <= {30'h00000000, cmp_q[9:8]};
					CTPWM_REG_STATUS: rdata_q <= {29'h00000000, pin_q, period_match_flag_q, match_a_flag_q};
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// prescalers run from reset so the first tick after enabling is not aligned
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			div4_q <= 2'h0;
			div16_q <= 4'h0;
			div64_q <= 6'h00;
			ext_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			div4_q <= div4_q + 2'h1;
			if (high_clk_en) begin
				div16_q <= div16_q + 4'h1;
				div64_q <= div64_q + 6'h01;
			end
			ext_q <= external_count_pin;
			run_q <= ctrl0_q.run;
		end
	end

	always_comb begin
		unique case (ctrl0_q.cksel)
			CTPWM_CK_SYS4: tick = div4_q == 2'(CTPWM_DIV_SYS4 - 1);
			CTPWM_CK_SYS: tick = 1'b1;
			CTPWM_CK_H16: tick = high_clk_en && div16_q == 4'(CTPWM_DIV_H16 - 1);
			CTPWM_CK_H64: tick = high_clk_en && div64_q == 6'(CTPWM_DIV_H64 - 1);
			CTPWM_CK_SUB0, CTPWM_CK_SUB1: tick = sub_clk_en;
			CTPWM_CK_PINR: tick = external_count_pin && !ext_q;
			CTPWM_CK_PINF: tick = !external_count_pin && ext_q;
		endcase
	end

	assign run_rise = ctrl0_q.run && !run_q;
	assign counting = ctrl0_q.run && !run_rise && !ctrl0_q.pause && tick;
	assign pwm_mode = ctrl1_q.mode == CTPWM_MODE_PWM;
	// matches look one count ahead so the clearing tick lands on zero and a period of n spans n ticks
	// a zero compare value never matches; the counter then wraps by overflow
	assign match_a = counting && cmp_q != '0 && count_q + 10'h001 == cmp_q;
	assign match_p = counting && ctrl0_q.period != 3'h0 && count_q == {ctrl0_q.period, 7'h00} - 10'h001;
	assign overflow = counting && count_q == 10'h3ff;

	// pwm compares the next count so a period of n*128 spans n*128 ticks
	assign pwm_period = ctrl1_q.pdsel ? {1'b0, cmp_q} : period_counts(ctrl0_q.period);
	assign pwm_duty = ctrl1_q.pdsel ? period_counts(ctrl0_q.period) : {1'b0, cmp_q};
	assign pwm_wave = pwm_duty >= pwm_period || {1'b0, count_q} < pwm_duty;

	always_comb begin
		if (pwm_mode) begin
			clear_cnt = counting && (11'(count_q) + 11'h001 >= pwm_period || overflow);
		end else if (ctrl1_q.clrsel) begin
			clear_cnt = match_a || overflow;
		end else begin
			clear_cnt = match_p || overflow;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= '0;
		end else if (run_rise) begin
			count_q <= '0;
		end else if (clear_cnt) begin
			count_q <= '0;
		end else if (counting) begin
			count_q <= count_q + 10'h001;
		end
	end

	// sticky event flags, cleared by writing one; a new event wins the clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			match_a_flag_q <= 1'b0;
			period_match_flag_q <= 1'b0;
			match_a_event <= 1'b0;
			period_match_event <= 1'b0;
		end else begin
			match_a_event <= match_a;
			period_match_event <= (pwm_mode || !ctrl1_q.clrsel) && (match_p || (ctrl0_q.period == 3'h0 && overflow));
			if (match_a) begin
				match_a_flag_q <= 1'b1;
			end else if (wr_status && av_req.writedata[0]) begin
				match_a_flag_q <= 1'b0;
			end
			if ((pwm_mode || !ctrl1_q.clrsel) && (match_p || (ctrl0_q.period == 3'h0 && overflow))) begin
				period_match_flag_q <= 1'b1;
			end else if (wr_status && av_req.writedata[1]) begin
				period_match_flag_q <= 1'b0;
			end
		end
	end

	// compare-mode pin state before polarity
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_q <= 1'b0;
		end else if (run_rise) begin
			pin_q <= ctrl1_q.octl;
		end else if (ctrl1_q.mode == CTPWM_MODE_CMP && match_a) begin
			unique case (ctrl1_q.ofn)
				2'b00: pin_q <= pin_q;
				2'b01: pin_q <= 1'b0;
				2'b10: pin_q <= 1'b1;
				2'b11: pin_q <= !pin_q;
			endcase
		end
	end

	always_comb begin
		unique case (ctrl1_q.ofn)
			2'b00: pin_level = !ctrl1_q.octl;
			2'b01: pin_level = ctrl1_q.octl;
			2'b10: pin_level = pwm_wave ? ctrl1_q.octl : !ctrl1_q.octl;
			2'b11: pin_level = !ctrl1_q.octl;
		endcase
	end

	// timer and undefined modes park the pin low
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_output_pin <= 1'b0;
		end else if (ctrl1_q.mode == CTPWM_MODE_PWM) begin
			timer_output_pin <= pin_level ^ ctrl1_q.pol;
		end else if (ctrl1_q.mode == CTPWM_MODE_CMP) begin
			timer_output_pin <= (run_rise ? ctrl1_q.octl : pin_q) ^ ctrl1_q.pol;
		end else begin
			timer_output_pin <= 1'b0;
		end
	end
endmodule

// ---- test/ctpwm_sva.sv ----
// checker for the timer: bus wait states, event spacing and pin levels
`timescale 1ns/1ps
module ctpwm_sva
	import ctpwm_pkg::*;
#(
	parameter int CNT_W = CTPWM_CNT_W
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire ctpwm_pkg::ctpwm_av_req_t av_req,
	input wire ctpwm_pkg::ctpwm_av_rsp_t av_rsp,
	input wire logic high_clk_en,
	input wire logic sub_clk_en,
	input wire logic external_count_pin,
	input wire logic timer_output_pin,
	input wire logic match_a_event,
	input wire logic period_match_event
);
	ctpwm_ctrl0_t c0_q;
	ctpwm_ctrl1_t c1_q;
	logic [1:0] calm_q;
	logic wr_c;
	// shadow of the control bytes; calm_q keeps checks off the cycles right after a change
	assign wr_c = av_req.write && av_req.byteenable[0] && av_req.address[2:1] == 2'h0;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			c0_q <= ctpwm_ctrl0_t'(CTPWM_CTRL0_RST);
			c1_q <= ctpwm_ctrl1_t'(CTPWM_CTRL1_RST);
			calm_q <= 2'h0;
		end else begin
			if (wr_c && !av_req.address[0]) c0_q <= ctpwm_ctrl0_t'(av_req.writedata[7:0]);
			if (wr_c && av_req.address[0]) c1_q <= ctpwm_ctrl1_t'(av_req.writedata[7:0]);
			calm_q <= wr_c ? 2'h0 : (calm_q == 2'h3 ? calm_q : calm_q + 2'h1);
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_write_no_wait: assert property (av_req.write |-> !av_rsp.waitrequest) else $error("write stalled");
	a_read_first_wait: assert property ($rose(av_req.read) |-> av_rsp.waitrequest) else $error("no read wait");
	a_read_one_wait: assert property (av_req.read && av_rsp.waitrequest |=> !av_rsp.waitrequest) else $error("long wait");
	a_idle_no_wait: assert property (!av_req.read |-> !av_rsp.waitrequest) else $error("idle wait");
	a_period_sparse: assert property (period_match_event |=> !period_match_event [*8]) else $error("period close");
	a_clrsel_no_pmatch: assert property (calm_q == 2'h3 && c1_q.clrsel && c1_q.mode != CTPWM_MODE_PWM
		|-> !period_match_event) else $error("period flag with clear select");
	a_timer_pin_low: assert property (calm_q == 2'h3 && c1_q.mode inside {CTPWM_MODE_TMR, CTPWM_MODE_UNDEF}
		|-> !timer_output_pin) else $error("pin driven in timer mode");
	a_pwm_forced_pin: assert property (calm_q == 2'h3 && c0_q.run && c1_q.mode == CTPWM_MODE_PWM && !c1_q.ofn[1]
		|-> timer_output_pin == ((c1_q.ofn[0] ~^ c1_q.octl) ^ c1_q.pol)) else $error("forced level");
	a_run_rise_init: assert property ($rose(c0_q.run) && c1_q.mode == CTPWM_MODE_CMP
		|-> ##2 timer_output_pin == (c1_q.octl ^ c1_q.pol)) else $error("initial level");
	c_period: cover property (period_match_event);
	c_match: cover property (match_a_event ##1 !match_a_event);
	c_pin_rise: cover property ($rose(timer_output_pin));
endmodule
bind ctpwm_top ctpwm_sva #(.CNT_W(CNT_W)) i_sva (.core_clk(core_clk), .arst_n(arst_n), .av_req(av_req),
	.av_rsp(av_rsp), .high_clk_en(high_clk_en), .sub_clk_en(sub_clk_en), .external_count_pin(external_count_pin),
	.timer_output_pin(timer_output_pin), .match_a_event(match_a_event), .period_match_event(period_match_event));

// ---- test/ctpwm_tb_top.sv ----
// self-checking bench for the timer: registers, counting, compare and pwm
`timescale 1ns/1ps
module ctpwm_tb_top;
	import ctpwm_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	ctpwm_av_req_t av_req = '0;
	ctpwm_av_rsp_t av_rsp;
	logic [2:0] pins = 3'h0;
	logic timer_output_pin;
	logic match_a_event;
	logic period_match_event;
	logic [7:0] rd;
	logic [9:0] v0;
	logic [9:0] v1;
	int mismatches = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;
	ctpwm_top #(.CNT_W(CTPWM_CNT_W)) i_dut (.core_clk(core_clk), .arst_n(arst_n), .av_req(av_req),
		.av_rsp(av_rsp), .high_clk_en(pins[0]), .sub_clk_en(pins[1]), .external_count_pin(pins[2]),
		.timer_output_pin(timer_output_pin), .match_a_event(match_a_event), .period_match_event(period_match_event));
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			$display("[ERR] %0t timeout", $time);
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input bit c, input string what);
		checks_done++;
		if (!c) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	// one full bus transfer; a write never waits, a read waits once
	task automatic bus(input int a, input int w, input logic [7:0] d);
		@(posedge core_clk);
		av_req <= '{address: a[2:0], read: w == 0, write: w != 0, byteenable: 4'h1, writedata: {24'h0, d}};
		@(posedge core_clk);
		while (av_rsp.waitrequest !== 1'b0) @(posedge core_clk);
		rd = av_rsp.readdata[7:0];
		av_req.read <= 1'b0;
		av_req.write <= 1'b0;
	endtask
	// high byte first so the low byte is latched with it
	task automatic rd_cnt(output logic [9:0] v);
		bus(3, 0, 8'h00);
		v[9:8] = rd[1:0];
		chk(rd[7:2] === 6'h00, "count high pad");
		bus(2, 0, 8'h00);
		v[7:0] = rd;
	endtask
	task automatic pulse(input int s, input int k);
		repeat (k) begin
			@(posedge core_clk);
			pins[s] <= 1'b1;
			@(posedge core_clk);
			pins[s] <= 1'b0;
			repeat (2) @(posedge core_clk);
		end
	endtask
	task automatic wev(input bit per, output int g);
		g = 0;
		do begin
			@(posedge core_clk);
			g++;
		end while ((per ? period_match_event : match_a_event) !== 1'b1 && g < 3000);
	endtask
	// a window of one whole period gives the duty whatever its phase
	task automatic hic(input int w, output int h);
		repeat (16) @(posedge core_clk);
		h = 0;
		repeat (w) begin
			@(posedge core_clk);
			h += int'(timer_output_pin === 1'b1);
		end
	endtask
	task automatic t_regs();
		bus(0, 0, 8'h00); chk(rd === CTPWM_CTRL0_RST, "ctrl0 reset");
		bus(1, 0, 8'h00); chk(rd === CTPWM_CTRL1_RST, "ctrl1 reset");
		bus(3, 1, 8'hff); bus(2, 1, 8'hff); bus(7, 1, 8'h5a);
		rd_cnt(v0); chk(v0 === 10'h000, "count not writable");
		bus(7, 0, 8'h00); chk(rd === 8'h00, "unmapped");
		bus(4, 1, 8'h5a); bus(5, 1, 8'hfe);
		bus(5, 0, 8'h00); chk(rd === 8'h02, "cmp high");
		bus(4, 1, 8'h11); bus(5, 0, 8'h00); bus(4, 0, 8'h00); chk(rd === 8'h5a, "cmp low latched");
		$display("test regs done");
	endtask
	task automatic t_count();
		ctpwm_cksel_t ck[6] = '{CTPWM_CK_H16, CTPWM_CK_H64, CTPWM_CK_SUB0, CTPWM_CK_SUB1, CTPWM_CK_PINR, CTPWM_CK_PINF};
		int src[6] = '{0, 0, 1, 1, 2, 2};
		int np[6] = '{32, 64, 3, 4, 5, 6};
		int ex[6] = '{2, 1, 3, 4, 5, 6};
		logic [9:0] v2;
		bus(1, 1, 8'hc0); bus(0, 1, 8'h18);
		repeat (300) @(posedge core_clk);
		bus(0, 1, 8'h98); rd_cnt(v0); repeat (40) @(posedge core_clk); rd_cnt(v1);
		chk(v1 === v0, "paused");
		chk(v0 > 10'd290 && v0 < 10'd330, "counted");
		bus(0, 1, 8'h18); repeat (20) @(posedge core_clk); rd_cnt(v2);
		chk(v2 > v1 && v2 < v1 + 10'd60, "resumed");
		bus(0, 1, 8'h10); rd_cnt(v0); repeat (40) @(posedge core_clk); rd_cnt(v1);
		chk(v1 === v0 && v0 > v2, "stopped");
		bus(0, 1, 8'h18); rd_cnt(v0); chk(v0 < 10'd16, "run rise clears");
		foreach (ck[i]) begin
			bus(0, 1, {1'b0, ck[i], 4'h0}); bus(0, 1, {1'b0, ck[i], 4'h8});
			pulse(src[i], np[i]);
			rd_cnt(v0); chk(v0 === ex[i][9:0], "clock source");
		end
		$display("test count done");
	endtask
	task automatic t_cmp();
		logic [7:0] p[3] = '{8'h19, 8'h1f, 8'h18};
		int pg[3] = '{128, 896, 1024};
		logic [7:0] c1v[7] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h19, 8'h29, 8'h2d};
		logic pa[7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		bus(0, 1, 8'h00); bus(1, 1, 8'h30); bus(4, 1, 8'h40); bus(5, 1, 8'h00);
		foreach (p[i]) begin
			bus(0, 1, p[i]); wev(1, n); wev(1, n); chk(n === pg[i], "period gap");
		end
		wev(0, n); wev(0, n); chk(n === 1024, "match a once per period");
		bus(0, 1, 8'h00); bus(1, 1, 8'h31); bus(0, 1, 8'h18);
		wev(0, n); wev(0, n); chk(n === 64, "match a clears");
		foreach (c1v[i]) begin
			bus(0, 1, 8'h00); bus(1, 1, c1v[i]); bus(0, 1, 8'h08);
			repeat (3) @(posedge core_clk);
			chk(timer_output_pin === (c1v[i][3] ^ c1v[i][2]), "initial level");
			wev(0, n); repeat (2) @(posedge core_clk);
			chk(timer_output_pin === pa[i], "match action");
		end
		$display("test compare done");
	endtask
	task automatic t_pwm();
		logic [7:0] c1v[5] = '{8'ha9, 8'hac, 8'ha8, 8'haa, 8'h98};
		logic [7:0] cl[5] = '{8'h20, 8'h20, 8'h90, 8'h00, 8'h00};
		logic [7:0] chh[5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
		int w[5] = '{128, 128, 128, 256, 20};
		int hx[5] = '{32, 96, 128, 128, 20};
		// run is dropped before every change of output function
		foreach (c1v[i]) begin
			bus(0, 1, 8'h00); bus(1, 1, c1v[i]); bus(4, 1, cl[i]); bus(5, 1, chh[i]); bus(0, 1, 8'h19);
			hic(w[i], n); chk(n === hx[i], "pwm high count");
		end
		$display("test pwm done");
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		t_regs();
		t_count();
		t_cmp();
		t_pwm();
		tally_and_finish();
	end
endmodule
